// ===== hdl/dpsm_pkg.sv
// Package for the drive power state machine: states, commands, option codes, timing.
// Assumes a single 125 MHz core clock domain.
package dpsm_pkg;
   // Automaton states of the drive
   typedef enum logic [2:0] {
      DPSM_NOT_READY,
      DPSM_SW_ON_DIS,
      DPSM_READY,
      DPSM_SWITCHED_ON,
      DPSM_OP_ENABLED,
      DPSM_QSTOP,
      DPSM_FAULT_REACT,
      DPSM_FAULT
   } dpsm_state_t;

   // Commands from the fieldbus master or the local source
   typedef enum logic [2:0] {
      DPSM_CMD_NONE,
      DPSM_CMD_SHUTDOWN,
      DPSM_CMD_SWITCH_ON,
      DPSM_CMD_DISABLE_VOLT,
      DPSM_CMD_QUICK_STOP,
      DPSM_CMD_DISABLE_OP,
      DPSM_CMD_ENABLE_OP,
      DPSM_CMD_FAULT_RESET
   } dpsm_cmd_t;

   localparam int DPSM_CMD_W = 3;
   localparam int DPSM_QSO_W = 4;
   localparam int DPSM_TRANS_W = 5;
   // Quick-stop option code ranges
   localparam logic [3:0] DPSM_QSO_AUTO_LO = 4'h1;
   localparam logic [3:0] DPSM_QSO_AUTO_HI = 4'h4;
   localparam logic [3:0] DPSM_QSO_HOLD_LO = 4'h5;
   localparam logic [3:0] DPSM_QSO_HOLD_HI = 4'h8;
   // Transition number reported when no transition fired
   localparam logic [4:0] DPSM_TRANS_NONE = 5'h1f;
   // Self-test duration after reset
   localparam int DPSM_CLK_MHZ = 125;
   localparam int DPSM_SELFTEST_NS = 1000;
   localparam int DPSM_SELFTEST_CYC = (DPSM_SELFTEST_NS * DPSM_CLK_MHZ + 999) / 1000;
endpackage

// ===== hdl/dpsm_reset_sync.sv
// Two-flop reset release synchroniser.
// Assumes the raw reset may assert at any time.
`timescale 1ns/10ps
module dpsm_reset_sync (
   // Clock and raw reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Synchronised reset
   output logic o_rst_n
);
   typedef struct packed {
      logic s1;
      logic s2;
   } dpsm_rs_state_t;

   dpsm_rs_state_t rs_reg;
   dpsm_rs_state_t rs_next;

   always_comb begin
      rs_next.s1 = 1'b1;
      rs_next.s2 = rs_reg.s1;
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rs_reg <= '0;
      end else begin
         rs_reg <= rs_next;
      end
   end

   assign o_rst_n = rs_reg.s2;
endmodule

// ===== hdl/dpsm_selftest.sv
// Self-initialisation timer run once after reset release.
// Assumes reset already synchronised to the core clock.
`timescale 1ns/10ps
module dpsm_selftest #(
   parameter int CYCLES = dpsm_pkg::DPSM_SELFTEST_CYC
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Status
   output logic o_done
);
   import dpsm_pkg::*;

   initial begin
      if (CYCLES < 1) begin
         $error("CYCLES must be at least one");
      end
   end

   typedef struct packed {
      logic [15:0] cnt;
      logic done;
   } dpsm_st_state_t;

   dpsm_st_state_t st_reg;
   dpsm_st_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!st_reg.done) begin
         if (st_reg.cnt == 16'(CYCLES - 1)) begin
            st_next.done = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_done = st_reg.done;
endmodule

// ===== hdl/dpsm_top.sv
// Drive power state machine: the drive_state_automaton of one servo axis, with
// brake, power and drive-function outputs tied to each state.
// Assumes commands arrive as one-cycle pulses synchronous to i_core_clk, and
// that the fault reaction and quick stop logic report completion by level.
`timescale 1ns/10ps

// Summary of operation
// - Brake held applied in the four pre-enabled states and fault.
// - Transition 0 runs self-test after reset; transition 1 activates communication.
// - Shutdown fires 2 (no action) or 8 (disable drive, power off).
// - Switch-on fires 3 and switches high-level power on.
// - Enable-operation fires 4, enables drive and clears set-points.
// - Disable-operation fires 5 and disables the drive function.
// - Shutdown while switched on fires 6 and switches power off.
// - Quick-stop or disable-voltage fires 7 with no action.
// - Disable-voltage fires 9: drive disabled, power off.
// - Disable-voltage or quick-stop fires 10, power off.
// - Quick-stop while enabled fires 11 and starts quick stop.
// - Quick stop done with option 1-4, or disable-voltage, fires 12.
// - Fault signal fires 13 from any state except fault reaction and fault, runs fault reaction.
// - Fault reaction done fires 14: drive disabled, power off.
// - Fault-reset fires 15 only when no fault is present.
// - Transition 16 from quick stop, option 5-8; off by default.
module dpsm_top #(
   parameter int SELFTEST_CYC = dpsm_pkg::DPSM_SELFTEST_CYC,
   parameter bit EN_TRANS16 = 1'b0
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Commands and option
   input wire dpsm_pkg::dpsm_cmd_t i_cmd,
   input wire logic [dpsm_pkg::DPSM_QSO_W-1:0] i_qstop_option,
   // Event inputs
   input wire logic i_fault,
   input wire logic i_qstop_done,
   input wire logic i_fault_react_done,
   // State and transition report
   output dpsm_pkg::dpsm_state_t o_state,
   output logic [dpsm_pkg::DPSM_TRANS_W-1:0] o_trans,
   // Power stage and function outputs
   output logic o_brake_applied,
   output logic o_hl_power_on,
   output logic o_drive_enable,
   output logic o_comm_active,
   output logic o_setpoint_clear,
   output logic o_qstop_start,
   output logic o_fault_react_start,
   output logic o_config_allowed
);
   import dpsm_pkg::*;

   initial begin
      if (SELFTEST_CYC < 1 || SELFTEST_CYC > 65535) begin
         $error("SELFTEST_CYC out of range");
      end
   end

   typedef struct packed {
      dpsm_state_t state;
      logic [DPSM_TRANS_W-1:0] trans;
      logic brake;
      logic hl_power;
      logic drive_en;
      logic comm;
      logic sp_clear;
      logic qs_start;
      logic fr_start;
   } dpsm_core_state_t;

   logic rst_n;
   logic selftest_done;
   logic qso_auto;
   logic qso_hold;
   dpsm_core_state_t core_reg;
   dpsm_core_state_t core_next;

   dpsm_reset_sync u_rst (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .o_rst_n(rst_n)
   );

   dpsm_selftest #(
      .CYCLES(SELFTEST_CYC)
   ) u_selftest (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .o_done(selftest_done)
   );

   assign qso_auto = (i_qstop_option >= DPSM_QSO_AUTO_LO) && (i_qstop_option <= DPSM_QSO_AUTO_HI);
   assign qso_hold = (i_qstop_option >= DPSM_QSO_HOLD_LO) && (i_qstop_option <= DPSM_QSO_HOLD_HI);

   always_comb begin
      core_next = core_reg;
      // Pulses last one cycle; unmatched commands leave everything else alone
      core_next.trans = DPSM_TRANS_NONE;
      core_next.sp_clear = 1'b0;
      core_next.qs_start = 1'b0;
      core_next.fr_start = 1'b0;
      if (i_fault && core_reg.state != DPSM_FAULT_REACT && core_reg.state != DPSM_FAULT) begin
         core_next.state = DPSM_FAULT_REACT;
         core_next.trans = 5'(13);
         core_next.fr_start = 1'b1;
      end else begin
         unique case (core_reg.state)
            DPSM_NOT_READY: begin
               if (selftest_done) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(1);
                  core_next.comm = 1'b1;
               end
            end
            DPSM_SW_ON_DIS: begin
               if (i_cmd == DPSM_CMD_SHUTDOWN) begin
                  core_next.state = DPSM_READY;
                  core_next.trans = 5'(2);
               end
            end
            DPSM_READY: begin
               if (i_cmd == DPSM_CMD_SWITCH_ON) begin
                  core_next.state = DPSM_SWITCHED_ON;
                  core_next.trans = 5'(3);
                  core_next.hl_power = 1'b1;
               end else if (i_cmd == DPSM_CMD_QUICK_STOP || i_cmd == DPSM_CMD_DISABLE_VOLT) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(7);
               end
            end
            DPSM_SWITCHED_ON: begin
               if (i_cmd == DPSM_CMD_ENABLE_OP) begin
                  core_next.state = DPSM_OP_ENABLED;
                  core_next.trans = 5'(4);
                  core_next.drive_en = 1'b1;
                  core_next.sp_clear = 1'b1;
               end else if (i_cmd == DPSM_CMD_SHUTDOWN) begin
                  core_next.state = DPSM_READY;
                  core_next.trans = 5'(6);
                  core_next.hl_power = 1'b0;
               end else if (i_cmd == DPSM_CMD_DISABLE_VOLT || i_cmd == DPSM_CMD_QUICK_STOP) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(10);
                  core_next.hl_power = 1'b0;
               end
            end
            DPSM_OP_ENABLED: begin
               if (i_cmd == DPSM_CMD_DISABLE_OP) begin
                  core_next.state = DPSM_SWITCHED_ON;
                  core_next.trans = 5'(5);
                  core_next.drive_en = 1'b0;
               end else if (i_cmd == DPSM_CMD_SHUTDOWN) begin
                  core_next.state = DPSM_READY;
                  core_next.trans = 5'(8);
                  core_next.drive_en = 1'b0;
                  core_next.hl_power = 1'b0;
               end else if (i_cmd == DPSM_CMD_DISABLE_VOLT) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(9);
                  core_next.drive_en = 1'b0;
                  core_next.hl_power = 1'b0;
               end else if (i_cmd == DPSM_CMD_QUICK_STOP) begin
                  core_next.state = DPSM_QSTOP;
                  core_next.trans = 5'(11);
                  core_next.qs_start = 1'b1;
               end
            end
            DPSM_QSTOP: begin
               if ((i_qstop_done && qso_auto) || i_cmd == DPSM_CMD_DISABLE_VOLT) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(12);
                  core_next.drive_en = 1'b0;
                  core_next.hl_power = 1'b0;
               end else if (EN_TRANS16 && qso_hold && i_cmd == DPSM_CMD_ENABLE_OP) begin
                  core_next.state = DPSM_OP_ENABLED;
                  core_next.trans = 5'(16);
                  core_next.drive_en = 1'b1;
               end
            end
            DPSM_FAULT_REACT: begin
               if (i_fault_react_done) begin
                  core_next.state = DPSM_FAULT;
                  core_next.trans = 5'(14);
                  core_next.drive_en = 1'b0;
                  core_next.hl_power = 1'b0;
               end
            end
            DPSM_FAULT: begin
               // reset only without a live fault
               if (i_cmd == DPSM_CMD_FAULT_RESET && !i_fault) begin
                  core_next.state = DPSM_SW_ON_DIS;
                  core_next.trans = 5'(15);
               end
            end
         endcase
      end
      unique case (core_next.state)
         DPSM_OP_ENABLED, DPSM_QSTOP, DPSM_FAULT_REACT: core_next.brake = 1'b0;
         default: core_next.brake = 1'b1;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reg.state <= DPSM_NOT_READY;
         core_reg.trans <= DPSM_TRANS_NONE;
         core_reg.brake <= 1'b1;
         core_reg.hl_power <= 1'b0;
         core_reg.drive_en <= 1'b0;
         core_reg.comm <= 1'b0;
         core_reg.sp_clear <= 1'b0;
         core_reg.qs_start <= 1'b0;
         core_reg.fr_start <= 1'b0;
      end else begin
         core_reg <= core_next;
      end
   end

   assign o_state = core_reg.state;
   assign o_trans = core_reg.trans;
   assign o_brake_applied = core_reg.brake;
   assign o_hl_power_on = core_reg.hl_power;
   assign o_drive_enable = core_reg.drive_en;
   assign o_comm_active = core_reg.comm;
   assign o_setpoint_clear = core_reg.sp_clear;
   assign o_qstop_start = core_reg.qs_start;
   assign o_fault_react_start = core_reg.fr_start;
   // Configuration locked while the drive function runs
   assign o_config_allowed = !core_reg.drive_en;
endmodule

// ===== test/dpsm_master_model.sv
// Command source model standing for the fieldbus master.
// Assumes the bench requests commands; the drive state is visible to it.
`timescale 1ns/10ps
module dpsm_master_model
   import dpsm_pkg::*;
(
   // Clock and bench request
   input wire logic i_core_clk,
   input wire dpsm_cmd_t i_req,
   input wire dpsm_state_t i_state,
   // Command to the drive
   output dpsm_cmd_t o_cmd
);
   logic hold_reg = 1'b0;
   always @(posedge i_core_clk) hold_reg <= o_cmd == DPSM_CMD_FAULT_RESET && i_state == DPSM_FAULT;
   // bench sets order
   // Held reset bit is gated by the live state so it drops the cycle the fault state is left
   assign o_cmd = (i_req != DPSM_CMD_NONE) ? i_req :
      ((hold_reg && i_state == DPSM_FAULT) ? DPSM_CMD_FAULT_RESET : DPSM_CMD_NONE);
endmodule

// ===== test/dpsm_top_monitor.sv
// Port checker for the drive power state machine.
// Assumes it is bound onto dpsm_top; one clock domain.
`timescale 1ns/10ps
module dpsm_top_monitor
   import dpsm_pkg::*;
#(
   parameter int SELFTEST_CYC = 5,
   parameter bit EN_TRANS16 = 1'b0
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Inputs of the block
   input wire dpsm_cmd_t i_cmd,
   input wire logic [3:0] i_qstop_option,
   input wire logic i_fault,
   input wire logic i_qstop_done,
   input wire logic i_fault_react_done,
   // Outputs of the block
   input wire dpsm_state_t o_state,
   input wire logic [4:0] o_trans,
   input wire logic o_brake_applied,
   input wire logic o_hl_power_on,
   input wire logic o_drive_enable,
   input wire logic o_comm_active,
   input wire logic o_setpoint_clear,
   input wire logic o_qstop_start,
   input wire logic o_fault_react_start,
   input wire logic o_config_allowed
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   logic act;
   logic pre;
   assign act = o_state inside {DPSM_OP_ENABLED, DPSM_QSTOP, DPSM_FAULT_REACT};
   assign pre = o_state inside {DPSM_NOT_READY, DPSM_SW_ON_DIS, DPSM_READY, DPSM_FAULT};
   sequence s_qs_auto;
      o_state == DPSM_QSTOP && i_qstop_done && !i_fault &&
         i_qstop_option inside {[DPSM_QSO_AUTO_LO:DPSM_QSO_AUTO_HI]};
   endsequence
   sequence s_off_12;
      o_state == DPSM_SW_ON_DIS && o_trans == 5'h0c && !o_hl_power_on && !o_drive_enable;
   endsequence
   a_brake_by_state: assert property (o_brake_applied == !act)
      else $error("brake level wrong for state");
   a_drive_by_state: assert property (pre |-> !o_drive_enable && o_config_allowed)
      else $error("drive enabled outside active states");
   a_power_by_state: assert property (pre && o_state != DPSM_SW_ON_DIS |-> !o_hl_power_on)
      else $error("power on in a powered-off state");
   a_enable_step: assert property (o_state == DPSM_SWITCHED_ON && i_cmd == DPSM_CMD_ENABLE_OP
      && !i_fault |=> o_state == DPSM_OP_ENABLED && o_trans == 5'h04 && o_setpoint_clear)
      else $error("enable operation step wrong");
   a_qstop_begin: assert property (o_state == DPSM_OP_ENABLED && i_cmd == DPSM_CMD_QUICK_STOP
      && !i_fault |=> o_state == DPSM_QSTOP && o_trans == 5'h0b && o_qstop_start)
      else $error("quick stop start wrong");
   a_qstop_auto: assert property (s_qs_auto |=> s_off_12 ##1 o_trans != 5'h0c)
      else $error("quick stop completion wrong");
   a_fault_entry: assert property (!pre && o_state != DPSM_FAULT_REACT && i_fault
      |=> o_state == DPSM_FAULT_REACT && o_trans == 5'h0d && o_fault_react_start)
      else $error("fault entry wrong");
   a_fault_exit: assert property (o_state == DPSM_FAULT_REACT && i_fault_react_done
      |=> o_state == DPSM_FAULT && o_trans == 5'h0e && !o_hl_power_on && o_brake_applied)
      else $error("fault reaction end wrong");
   a_fault_reset: assert property (o_state == DPSM_FAULT && i_cmd == DPSM_CMD_FAULT_RESET
      |=> o_state == ($past(i_fault) ? DPSM_FAULT : DPSM_SW_ON_DIS))
      else $error("fault reset handling wrong");
   a_ignore_cmd: assert property (o_state == DPSM_SW_ON_DIS && !i_fault && i_cmd inside
      {DPSM_CMD_NONE, DPSM_CMD_SWITCH_ON, DPSM_CMD_ENABLE_OP, DPSM_CMD_DISABLE_OP}
      |=> o_state == DPSM_SW_ON_DIS && o_trans == 5'h1f)
      else $error("undefined command not ignored");
   a_comm_start: assert property ($rose(o_comm_active) |-> o_state == DPSM_SW_ON_DIS
      && o_trans == 5'h01)
      else $error("communication start wrong");
   a_no_trans16: assert property (!EN_TRANS16 && o_state == DPSM_QSTOP && !i_fault
      && !i_qstop_done && i_cmd == DPSM_CMD_ENABLE_OP |=> o_state == DPSM_QSTOP)
      else $error("transition 16 taken while off");
endmodule

bind dpsm_top dpsm_top_monitor #(.SELFTEST_CYC(SELFTEST_CYC), .EN_TRANS16(EN_TRANS16)) u_mon (
   .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cmd(i_cmd),
   .i_qstop_option(i_qstop_option), .i_fault(i_fault), .i_qstop_done(i_qstop_done),
   .i_fault_react_done(i_fault_react_done), .o_state(o_state), .o_trans(o_trans),
   .o_brake_applied(o_brake_applied), .o_hl_power_on(o_hl_power_on),
   .o_drive_enable(o_drive_enable), .o_comm_active(o_comm_active),
   .o_setpoint_clear(o_setpoint_clear), .o_qstop_start(o_qstop_start),
   .o_fault_react_start(o_fault_react_start), .o_config_allowed(o_config_allowed));

// ===== test/tb_dpsm_top.sv
// Self-checking bench for the drive power state machine.
// Assumes the command source model and the port checker are compiled first.
`timescale 1ns/10ps
module tb_dpsm_top;
   import dpsm_pkg::*;
   localparam int ST_CYC = 4;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   dpsm_cmd_t req = DPSM_CMD_NONE;
   dpsm_cmd_t cmd;
   logic [3:0] qso = 4'h1;
   logic fault = 1'b0;
   logic qdone = 1'b0;
   logic frdone = 1'b0;
   dpsm_state_t state;
   logic [4:0] trans;
   logic [7:0] notes[$];
   int mismatches = 0;
   int checked = 0;
   always #4 clk = ~clk;
   dpsm_master_model u_dpsm_master_model (.i_core_clk(clk), .i_req(req), .i_state(state),
      .o_cmd(cmd));
   dpsm_top #(.SELFTEST_CYC(ST_CYC)) u_dpsm_top (.i_core_clk(clk), .i_arst_n(arst_n),
      .i_cmd(cmd), .i_qstop_option(qso), .i_fault(fault), .i_qstop_done(qdone),
      .i_fault_react_done(frdone), .o_state(state), .o_trans(trans), .o_brake_applied(),
      .o_hl_power_on(), .o_drive_enable(), .o_comm_active(), .o_setpoint_clear(),
      .o_qstop_start(), .o_fault_react_start(), .o_config_allowed());
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Event bits: fault, quick stop done, reaction done, high option range
   task automatic step(input dpsm_cmd_t c, input logic [3:0] ev, input logic [4:0] t,
      input dpsm_state_t s);
      @(negedge clk);
      req <= c;
      fault <= ev[0];
      qdone <= ev[1];
      frdone <= ev[2];
      qso <= ev[3] ? 4'($urandom_range(8, 5)) : 4'($urandom_range(4, 1));
      if (t != 5'h1f) notes.push_back({t, s});
   endtask
   task automatic up();
      step(DPSM_CMD_SHUTDOWN, 4'h0, 5'd2, DPSM_READY);
      step(DPSM_CMD_SWITCH_ON, 4'h0, 5'd3, DPSM_SWITCHED_ON);
      step(DPSM_CMD_ENABLE_OP, 4'h0, 5'd4, DPSM_OP_ENABLED);
   endtask
   // Each transition report is matched with the oldest expectation
   always @(negedge clk) begin
      if (arst_n && trans !== 5'h1f) begin
         if (notes.size() == 0) cmp({trans, state}, 8'hff);
         else cmp({trans, state}, notes.pop_front());
      end
   end
   initial begin
      int n;
      void'($urandom(32'he663));
      repeat (3) @(posedge clk);
      @(negedge clk);
      arst_n <= 1'b1;
      notes.push_back({5'd1, DPSM_SW_ON_DIS});
      n = 0;
      while (state !== DPSM_SW_ON_DIS && n < ST_CYC + 20) begin
         @(negedge clk);
         n++;
      end
      if (state !== DPSM_SW_ON_DIS) begin
         mismatches++;
         close_out();
      end
      step(DPSM_CMD_ENABLE_OP, 4'h0, 5'h1f, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_DISABLE_OP, 4'h0, 5'd5, DPSM_SWITCHED_ON);
      step(DPSM_CMD_SHUTDOWN, 4'h0, 5'd6, DPSM_READY);
      step(DPSM_CMD_QUICK_STOP, 4'h0, 5'd7, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_SHUTDOWN, 4'h0, 5'd8, DPSM_READY);
      step(DPSM_CMD_SWITCH_ON, 4'h0, 5'd3, DPSM_SWITCHED_ON);
      step(DPSM_CMD_DISABLE_VOLT, 4'h0, 5'd10, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_DISABLE_VOLT, 4'h0, 5'd9, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_QUICK_STOP, 4'h0, 5'd11, DPSM_QSTOP);
      step(DPSM_CMD_NONE, 4'h2, 5'd12, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_QUICK_STOP, 4'h0, 5'd11, DPSM_QSTOP);
      step(DPSM_CMD_ENABLE_OP, 4'ha, 5'h1f, DPSM_QSTOP);
      step(DPSM_CMD_DISABLE_VOLT, 4'h8, 5'd12, DPSM_SW_ON_DIS);
      step(DPSM_CMD_NONE, 4'h1, 5'd13, DPSM_FAULT_REACT);
      step(DPSM_CMD_FAULT_RESET, 4'h5, 5'd14, DPSM_FAULT);
      step(DPSM_CMD_FAULT_RESET, 4'h1, 5'h1f, DPSM_FAULT);
      step(DPSM_CMD_NONE, 4'h0, 5'd15, DPSM_SW_ON_DIS);
      up();
      step(DPSM_CMD_SHUTDOWN, 4'h1, 5'd13, DPSM_FAULT_REACT);
      step(DPSM_CMD_NONE, 4'h5, 5'd14, DPSM_FAULT);
      step(DPSM_CMD_FAULT_RESET, 4'h0, 5'd15, DPSM_SW_ON_DIS);
      step(DPSM_CMD_NONE, 4'h0, 5'h1f, DPSM_SW_ON_DIS);
      repeat (3) @(negedge clk);
      cmp(8'(notes.size()), 8'h00);
      close_out();
   end
endmodule
